// file: rtl/ubm_map.vh
// Constants for the unsigned byte multiplier: encodings, phases, resets.
`ifndef UBM_MAP_VH
`define UBM_MAP_VH
`define UBM_OPC_MUL_LIT 8'h0D
`define UBM_OPC_MUL_REG 7'h01
`define UBM_OPC_LOAD_BANK 8'h01
`define UBM_OPC_HI_MSB 15
`define UBM_OPC_HI_LSB 8
`define UBM_OPC_REG_LSB 9
`define UBM_BANK_BIT 8
`define UBM_PH_Q1 2'h0
`define UBM_PH_Q2 2'h1
`define UBM_PH_Q3 2'h2
`define UBM_PH_Q4 2'h3
`define UBM_RST_BYTE 8'h00
`define UBM_RST_WORD 16'h0000
`define UBM_ACCESS_SPLIT 8'h80
`define UBM_ACCESS_HI_BANK 4'hF
`define UBM_BANK_ZERO 4'h0
`endif

// file: rtl/ubm_multiplier.v
// Unsigned 8x8 multiply instructions with the product register pair.
// What this block does
// - Literal multiply: working register times instruction low-byte literal.
// - Register multiply: working register times the addressed data-memory byte.
// - Product written whole: high byte to product high, low to product low.
// - Working register and memory operand are never written by a multiply.
// - No status flag changes; zero, carry and overflow are not flagged.
// - Bank-mode bit 0 uses access bank; bit 1 uses bank select register.
// - Bank select register holds 8-bit bank number loaded by a literal op.
`timescale 1ns/1ps
`include "ubm_map.vh"

module ubm_multiplier #(
  parameter DW = 8,
  parameter AW = 12
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_cycle_start,
  input wire [15:0] i_instr,
  input wire [DW-1:0] i_wreg,
  input wire [DW-1:0] i_mem_rdata,
  output reg [AW-1:0] o_mem_addr,
  output reg o_mem_rd,
  output reg [DW-1:0] o_product_high,
  output reg [DW-1:0] o_product_low,
  output reg [DW-1:0] o_bank_select_register,
  output reg o_prod_wr,
  output reg [1:0] o_phase
);

  reg [1:0] phase_reg;
  reg running_reg;
  reg is_lit_reg;
  reg is_reg_reg;
  reg is_bank_reg;
  reg [DW-1:0] lit_reg;
  reg [DW-1:0] opb_reg;
  reg [2*DW-1:0] prod_reg;
  reg [AW-1:0] addr_next;
  wire [7:0] hi_byte;
  wire [6:0] hi_seven;
  // Running sums of the shifted partial products, one stage per operand bit.
  wire [2*DW-1:0] pp_sum [0:DW];
  genvar gi;

  // A plain shift-and-add array keeps the product unsigned by construction.
  // Neither operand is sign-extended, so no carry or overflow can arise.
  assign pp_sum[0] = {2*DW{1'b0}};
  generate
    for (gi = 0; gi < DW; gi = gi + 1) begin : g_pp
      wire [2*DW-1:0] pp;
      assign pp = opb_reg[gi] ? ({{DW{1'b0}}, i_wreg} << gi) :
        {2*DW{1'b0}};
      assign pp_sum[gi+1] = pp_sum[gi] + pp;
    end
  endgenerate

  assign hi_byte = i_instr[`UBM_OPC_HI_MSB:`UBM_OPC_HI_LSB];
  assign hi_seven = i_instr[`UBM_OPC_HI_MSB:`UBM_OPC_REG_LSB];

  // Access bank splits into low bank-zero bytes and high special bytes.
  always @* begin
    if (!i_instr[`UBM_BANK_BIT]) begin
      if (i_instr[7:0] < `UBM_ACCESS_SPLIT) begin
        addr_next = {`UBM_BANK_ZERO, i_instr[7:0]};
      end else begin
        addr_next = {`UBM_ACCESS_HI_BANK, i_instr[7:0]};
      end
    end else begin
      // Only the low bank bits reach the address; upper ones are stored.
      addr_next = {o_bank_select_register[AW-9:0], i_instr[7:0]};
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      phase_reg <= `UBM_PH_Q1;
      running_reg <= 1'b0;
      is_lit_reg <= 1'b0;
      is_reg_reg <= 1'b0;
      is_bank_reg <= 1'b0;
      lit_reg <= `UBM_RST_BYTE;
      opb_reg <= `UBM_RST_BYTE;
      prod_reg <= `UBM_RST_WORD;
      o_mem_addr <= {AW{1'b0}};
      o_mem_rd <= 1'b0;
      o_product_high <= `UBM_RST_BYTE;
      o_product_low <= `UBM_RST_BYTE;
      o_bank_select_register <= `UBM_RST_BYTE;
      o_prod_wr <= 1'b0;
      o_phase <= `UBM_PH_Q1;
    end else begin
      o_mem_rd <= 1'b0;
      o_prod_wr <= 1'b0;
      if (i_cycle_start && !running_reg) begin
        // Q1: decode.
        running_reg <= 1'b1;
        phase_reg <= `UBM_PH_Q2;
        o_phase <= `UBM_PH_Q2;
        is_lit_reg <= (hi_byte == `UBM_OPC_MUL_LIT);
        is_reg_reg <= (hi_seven == `UBM_OPC_MUL_REG);
        is_bank_reg <= (hi_byte == `UBM_OPC_LOAD_BANK);
        lit_reg <= i_instr[7:0];
        o_mem_addr <= addr_next;
        o_mem_rd <= (hi_seven == `UBM_OPC_MUL_REG);
      end else if (running_reg) begin
        case (phase_reg)
          `UBM_PH_Q2: begin
            // Operand read; memory is only read, never written.
            opb_reg <= is_reg_reg ? i_mem_rdata : lit_reg;
            phase_reg <= `UBM_PH_Q3;
            o_phase <= `UBM_PH_Q3;
          end
          `UBM_PH_Q3: begin
            // The working register is only read here; it has no write path.
            prod_reg <= pp_sum[DW];
            phase_reg <= `UBM_PH_Q4;
            o_phase <= `UBM_PH_Q4;
          end
          `UBM_PH_Q4: begin
            // No flags exist here: a zero product is deliberately unreported.
            if (is_lit_reg || is_reg_reg) begin
              o_product_high <= prod_reg[2*DW-1:DW];
              o_product_low <= prod_reg[DW-1:0];
              o_prod_wr <= 1'b1;
            end
            if (is_bank_reg) begin
              o_bank_select_register <= lit_reg;
            end
            running_reg <= 1'b0;
            phase_reg <= `UBM_PH_Q1;
            o_phase <= `UBM_PH_Q1;
          end
          default: begin
            phase_reg <= `UBM_PH_Q1;
            running_reg <= 1'b0;
            o_phase <= `UBM_PH_Q1;
          end
        endcase
      end
    end
  end

endmodule // ubm_multiplier

// file: tb/ubm_multiplier_chk.sv
// Port checker for the unsigned byte multiplier.
`timescale 1ns/1ps
module ubm_multiplier_chk #(parameter DW = 8, parameter AW = 12) (
  input wire i_clk, input wire i_rst, input wire i_cycle_start,
  input wire [15:0] i_instr, input wire [DW-1:0] i_wreg,
  input wire [DW-1:0] i_mem_rdata, input wire [AW-1:0] o_mem_addr,
  input wire o_mem_rd, input wire [DW-1:0] o_product_high,
  input wire [DW-1:0] o_product_low, input wire o_prod_wr,
  input wire [DW-1:0] o_bank_select_register, input wire [1:0] o_phase);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire tk = i_cycle_start && o_phase == 2'h0;
  wire lit = tk && i_instr[15:8] == 8'h0D;
  wire rgm = tk && i_instr[15:9] == 7'h01;
  wire [15:0] pr = {o_product_high, o_product_low};
  cyc_walk_a:
    assert property ((lit || rgm) |=> o_phase == 2'h1 ##1 o_phase == 2'h2
      ##1 o_phase == 2'h3 ##1 o_prod_wr) else $error("phase walk");
  wr_slot_a:
    assert property (o_prod_wr |-> $past(o_phase) == 2'h3) else $error("wr");
  rd_slot_a:
    assert property (o_mem_rd |-> o_phase == 2'h1 && i_instr[15:9] == 7'h01)
      else $error("read slot");
  addr_map_a:
    assert property (o_mem_rd |-> o_mem_addr == (i_instr[8] ?
      {o_bank_select_register[3:0], i_instr[7:0]} :
      {{4{i_instr[7]}}, i_instr[7:0]})) else $error("address");
  lit_prod_a:
    assert property (lit |-> ##4 pr == i_wreg * i_instr[7:0])
      else $error("literal product");
  reg_prod_a:
    assert property (rgm |-> ##4 pr == i_wreg * $past(i_mem_rdata, 3))
      else $error("register product");
  prod_hold_a:
    assert property (!o_prod_wr |-> $stable(pr)) else $error("hold");
  bank_keep_a:
    assert property (o_phase != 2'h0 |-> $stable(o_bank_select_register))
      else $error("bank");
endmodule // ubm_multiplier_chk
bind ubm_multiplier ubm_multiplier_chk #(.DW(DW), .AW(AW)) u_chk (.*);

// file: tb/ubm_multiplier_tb_top.sv
// Self-checking bench for the unsigned byte multiplier.
`timescale 1ns/1ps
module ubm_multiplier_tb_top;
  reg i_clk = 0, i_rst = 1, i_cycle_start = 0;
  reg [15:0] i_instr = 16'h0000;
  reg [7:0] i_wreg = 8'h00, i_mem_rdata = 8'h00;
  wire [11:0] o_mem_addr;
  wire [7:0] o_product_high, o_product_low, o_bank_select_register;
  wire o_mem_rd, o_prod_wr;
  wire [1:0] o_phase;
  wire [15:0] pr = {o_product_high, o_product_low};
  integer miscompares = 0, checks_done = 0, cyc = 0;
  reg [11:0] ad;
  ubm_multiplier u_ubm_multiplier (.*);
  initial forever #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc > 500) begin
    miscompares++;
    wrap_up;
  end
  task chk(input [15:0] s, input [15:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  // Address is captured while the operand read is out.
  task op(input [15:0] n, input [7:0] w, input [7:0] m);
    @(posedge i_clk) #1 {i_cycle_start, i_instr, i_wreg} = {1'b1, n, w};
    @(posedge i_clk) #1 {i_cycle_start, i_mem_rdata} = {1'b0, m};
    ad = o_mem_addr;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task lit_cases;
    op(16'h0DC4, 8'hE2, 8'h00); chk(pr, 16'hAD08);
    op(16'h0DFF, 8'hFF, 8'h00); chk(pr, 16'hFE01);
    op(16'h0D00, 8'h5A, 8'h00); chk(pr, 16'h0000);
  endtask
  task reg_cases;
    op(16'h0105, 8'h00, 8'h00); chk(o_bank_select_register, 16'h5);
    op(16'h0310, 8'hC4, 8'hB5); chk(pr, 16'h8A94);
    chk(ad, 16'h0510);
    op(16'h0290, 8'h03, 8'hFF); chk(ad, 16'h0F90);
    chk(pr, 16'h02FD);
    op(16'h0000, 8'h07, 8'h07); chk(pr, 16'h02FD);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_rst = 0;
    lit_cases;
    reg_cases;
    wrap_up;
  end
endmodule // ubm_multiplier_tb_top
